// ==== prot_alarm_pkg.sv ====
// Shared constants, types and state records for the protection block.
// Assumes a single 100 MHz system clock and a synchronous reset.
package prot_alarm_pkg;

    // Clock and timing base
    localparam int CLK_PERIOD_NS = 10;
    localparam int FB_STEP_MS = 100;      // Delay step, 0.1 s
    localparam int FB_STEP_NS = FB_STEP_MS * 1000000;
    localparam int TICK_CYCLES_DFLT = FB_STEP_NS / CLK_PERIOD_NS;
    localparam int HOLD_MS = 3000;        // Enter button hold time
    localparam int HOLD_TICKS = HOLD_MS / FB_STEP_MS;
    localparam int PRE_W = 24;            // Prescaler width
    localparam int DLY_W = 9;             // Delay field width
    localparam int HOLD_W = 6;            // Hold tick counter width
    localparam int ALM_W = 9;             // Alarm mask width
    localparam int PIN_W = 13;            // Synchronised pin bundle

    // Alarm bit positions
    localparam int ALM_FAN = 1;
    localparam int ALM_FAN_SLV = 2;
    localparam int ALM_OTP = 3;
    localparam int ALM_OTP_SLV = 4;
    localparam int ALM_FB = 7;
    localparam int ALM_SHDN = 8;
    localparam logic [ALM_W-1:0] ALM_USED = 9'h19e;
    localparam logic [ALM_W-1:0] MASK_RST = 9'h000;

    // Status word bit positions above the alarm bits
    localparam int ST_ILK = 9;
    localparam int ST_OFF = 10;

    // Argument limits, in command argument units
    localparam logic [15:0] ARG_DLY_MIN = 16'h0005;
    localparam logic [15:0] ARG_DLY_MAX = 16'h01f4;
    localparam logic [15:0] ARG_LVL_MIN = 16'h0002;
    localparam logic [15:0] ARG_LVL_MAX = 16'h000a;
    localparam logic [15:0] ARG_SLOT_MIN = 16'h0001;
    localparam logic [15:0] ARG_SLOT_MAX = 16'h0003;
    localparam logic [15:0] ARG_SEL_MAX = 16'h0002;
    localparam logic [DLY_W-1:0] DLY_RST = 9'h005;
    localparam logic [3:0] LVL_RST = 4'ha;

    typedef enum logic [1:0] {
        FB_DISABLED = 2'h0,
        CONSTANT_CURRENT_TRIGGER = 2'h1,
        CONSTANT_VOLTAGE_TRIGGER = 2'h2
    } fb_mode_t;

    typedef enum logic [1:0] {
        SRC_LOCAL = 2'h0,
        ANALOG_VOLTAGE_SOURCE = 2'h1,
        RESISTIVE_SOURCE = 2'h2
    } src_t;

    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_FB_MODE = 4'h1,
        OP_FB_DELAY = 4'h2,
        OP_ALARM_MASK = 4'h3,
        OP_OT_LATCH = 4'h4,
        OP_ILK = 4'h5,
        OP_SAVE = 4'h6,
        OP_RECALL = 4'h7,
        OP_LEVEL = 4'h8,
        OP_SOURCE = 4'h9,
        OP_PROT_CLEAR = 4'ha,
        OP_QUERY = 4'hb
    } cmd_op_t;

    typedef enum logic [2:0] {
        FB_IDLE = 3'h1,
        FB_COUNT = 3'h2,
        FB_TRIP = 3'h4
    } fb_state_t;

    // Index 0 V non-isolated, 1 V isolated, 2 I non-isolated, 3 I isolated
    typedef struct packed {
        fb_mode_t fbMode;
        logic [DLY_W-1:0] fbDelay;
        logic [3:0][3:0] analogFullscaleLevel;
        src_t [3:0] source;
    } usr_cfg_t;

    localparam usr_cfg_t CFG_RST = '{FB_DISABLED, DLY_RST,
        {LVL_RST, LVL_RST, LVL_RST, LVL_RST},
        {SRC_LOCAL, SRC_LOCAL, SRC_LOCAL, SRC_LOCAL}};

    typedef struct packed {
        logic valid;
        cmd_op_t op;
        logic [1:0] sel;
        logic [15:0] arg;
    } cmd_t;

    typedef struct packed {
        logic valid;
        logic ok;
        logic [15:0] data;
    } rsp_t;

    typedef struct packed {
        usr_cfg_t cfg;
        logic [ALM_W-1:0] alarmDisableMask;
        logic otLatchEn;
        logic ilkEn;
        fb_state_t fbState;
        logic [PRE_W-1:0] fbPre;
        logic [DLY_W-1:0] fbCnt;
        logic [PRE_W-1:0] holdPre;
        logic [HOLD_W-1:0] holdCnt;
        logic holdArmed;
        logic otLatched;
        logic outputOff;
        logic alarmOut;
        logic statusEvent;
        logic [ALM_W:0] prevVisible;
        logic recallPend;
        rsp_t rsp;
    } prot_state_t;

endpackage

// ==== pin_sync.sv ====
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous pins; output moves once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;   // Read only by s2
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_state_t;

    sync_state_t s;
    sync_state_t n;

    // Next state: shift, accept only agreed samples
    always_comb begin
        n = s;
        n.s1 = din;
        n.s2 = s.s1;
        n.s3 = s.s2;
        for (int i = 0; i < W; i++) begin
            if (s.s2[i] == s.s3[i]) begin
                n.q[i] = s.s3[i];
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign dout = s.q;
endmodule
`default_nettype wire

// ==== cfg_slot_mem.sv ====
// Three-slot store for user settings, registered read data.
// Assumes slot numbers 1 to 3 already checked by the caller.
`timescale 1ns/1ps
`default_nettype none
module cfg_slot_mem (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wrEn,
    input wire logic rdEn,
    input wire logic [1:0] slot,
    input wire prot_alarm_pkg::usr_cfg_t wrData,
    output prot_alarm_pkg::usr_cfg_t rdData
);
    import prot_alarm_pkg::*;

    typedef struct packed {
        usr_cfg_t [3:0] slots;   // Entry 0 unused
        usr_cfg_t rd;
    } mem_state_t;

    mem_state_t s;
    mem_state_t n;

    // Write or read one slot per command
    always_comb begin
        n = s;
        if (wrEn) begin
            n.slots[slot] = wrData;
        end
        if (rdEn) begin
            n.rd = s.slots[slot];
        end
    end

    // Slots come up holding defaults
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s <= '{slots: {4{CFG_RST}}, rd: CFG_RST};
        end else begin
            s <= n;
        end
    end

    assign rdData = s.rd;
endmodule
`default_nettype wire

// ==== protection_alarm_control.sv ====
// Foldback shutdown, alarm masking and latching, interlock and settings.
// Assumes decoded commands on the same clock; status pins are async.
// Overview of operation
// - Foldback trigger: current, voltage, or disabled
// - In selected mode count delay, then shut down
// - Counter idle in any other regulation mode
// - Reset leaves foldback trigger disabled
// - Delay 0.5 to 50 s, 0.1 s steps
// - Reset delay is half a second
// - Foldback clear needs 3 s enter hold plus command
// - Mask bit disables over-temperature alarm
// - Latch flag holds over-temperature alarm until cleared
// - Interlock disabled after reset until enabled
// - Interlock ignores mask and latch settings
// - Interlock enable changes only by remote command
// - Save and recall slots one to three
// - Full-scale level two to ten per path
// - Source local, analog voltage or resistive
// - Masked alarms hidden from all status
// - Mask bits 1,2,3,4,7,8; others unused
`timescale 1ns/1ps
`default_nettype none
module protection_alarm_control #(
    parameter int TICK_CYCLES = prot_alarm_pkg::TICK_CYCLES_DFLT
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire prot_alarm_pkg::cmd_t cmd,
    input wire logic regCurrentPin,
    input wire logic regVoltagePin,
    input wire logic enterBtnPin,
    input wire logic [prot_alarm_pkg::ALM_W-1:0] alarmPin,
    input wire logic interlockPin,
    output prot_alarm_pkg::rsp_t rsp,
    output logic outputOff,
    output logic alarmOut,
    output logic statusEvent,
    output prot_alarm_pkg::usr_cfg_t usrCfg
);
    import prot_alarm_pkg::*;

    // Last prescaler count of one 0.1 s step
    localparam logic [PRE_W-1:0] TICK_LAST = PRE_W'(TICK_CYCLES - 1);
    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_TICKS);

    prot_state_t s;            // Registered state
    prot_state_t n;            // Next state
    logic [PIN_W-1:0] pinSync; // Filtered pins
    usr_cfg_t memRd;           // Recalled settings
    logic memWr;               // Save strobe
    logic memRdEn;             // Recall strobe
    logic inSel;               // Regulating in the selected mode
    logic fbTick;              // Foldback step elapsed
    logic clrCmd;              // Protection clear command
    logic slotOk;              // Slot argument in range
    logic [ALM_W-1:0] cond;    // Raw alarm conditions
    logic [ALM_W:0] visAll;    // Host-visible alarms plus interlock

    // Status pins, delivered as one bundle
    pin_sync #(
        .W(PIN_W)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .din({interlockPin, enterBtnPin, regVoltagePin, regCurrentPin,
            alarmPin}),
        .dout(pinSync)
    );

    // Settings slots for save and recall
    cfg_slot_mem u_mem (
        .clk_sys(clk_sys),
        .rst(rst),
        .wrEn(memWr),
        .rdEn(memRdEn),
        .slot(cmd.arg[1:0]),
        .wrData(s.cfg),
        .rdData(memRd)
    );

    // True when an argument lies inside an inclusive range
    function automatic logic inRange(input logic [15:0] v,
        input logic [15:0] lo, input logic [15:0] hi);
        inRange = (v >= lo) && (v <= hi);
    endfunction

    // Command decode helpers
    always_comb begin
        clrCmd = cmd.valid && (cmd.op == OP_PROT_CLEAR);
        slotOk = inRange(cmd.arg, ARG_SLOT_MIN, ARG_SLOT_MAX);
        memWr = cmd.valid && (cmd.op == OP_SAVE) && slotOk;
        memRdEn = cmd.valid && (cmd.op == OP_RECALL) && slotOk;
    end

    // Trigger qualification from the filtered regulation status
    always_comb begin
        case (s.cfg.fbMode)
            CONSTANT_CURRENT_TRIGGER: inSel = pinSync[ALM_W];
            CONSTANT_VOLTAGE_TRIGGER: inSel = pinSync[ALM_W+1];
            default: inSel = 1'b0;
        endcase
        fbTick = (s.fbPre == TICK_LAST);
    end

    // Alarm conditions; bit 7 comes from the foldback trip only
    always_comb begin
        cond = pinSync[ALM_W-1:0] & ALM_USED;
        cond[ALM_FB] = (s.fbState == FB_TRIP);
        cond[ALM_OTP] = cond[ALM_OTP] | s.otLatched;
        // Masked bits never reach status or the event logic
        visAll = {s.ilkEn & pinSync[PIN_W-1],
            cond & ~s.alarmDisableMask & ALM_USED};
    end

    // Whole next-state function
    always_comb begin
        n = s;
        n.rsp = '0;
        n.recallPend = 1'b0;

        // Foldback sequence
        case (s.fbState)
            FB_IDLE: begin
                n.fbPre = '0;
                n.fbCnt = '0;
                if (inSel) begin
                    n.fbState = FB_COUNT;
                end
            end
            FB_COUNT: begin
                if (!inSel) begin
                    n.fbState = FB_IDLE;
                end else if (fbTick) begin
                    n.fbPre = '0;
                    n.fbCnt = s.fbCnt + 9'h001;
                    if (n.fbCnt >= s.cfg.fbDelay) begin
                        n.fbState = FB_TRIP;
                    end
                end else begin
                    n.fbPre = s.fbPre + 24'h000001;
                end
            end
            FB_TRIP: begin
                // Only the held button plus the command releases it
                if (clrCmd && s.holdArmed) begin
                    n.fbState = FB_IDLE;
                end
            end
            default: n.fbState = FB_IDLE;
        endcase
        n.outputOff = (n.fbState == FB_TRIP);

        // Enter button hold timer, restarted on every release
        if (pinSync[PIN_W-2]) begin
            if (s.holdPre == TICK_LAST) begin
                n.holdPre = '0;
                // Saturates, so a long hold stays armed
                if (s.holdCnt != HOLD_LAST) begin
                    n.holdCnt = s.holdCnt + 6'h01;
                end
            end else begin
                n.holdPre = s.holdPre + 24'h000001;
            end
        end else begin
            n.holdPre = '0;
            n.holdCnt = '0;
        end
        n.holdArmed = (n.holdCnt == HOLD_LAST);

        // Over-temperature latch: clear first, a new trip wins
        if (!s.otLatchEn) begin
            n.otLatched = 1'b0;
        end else if (clrCmd && !pinSync[ALM_OTP]) begin
            n.otLatched = 1'b0;
        end
        if (s.otLatchEn && pinSync[ALM_OTP]
            && !s.alarmDisableMask[ALM_OTP]) begin
            n.otLatched = 1'b1;
        end

        // Summary alarm and event on any newly visible alarm
        n.prevVisible = visAll;
        n.alarmOut = |visAll;
        n.statusEvent = |(visAll & ~s.prevVisible);

        // Recalled settings land one cycle after the command
        if (s.recallPend) begin
            n.cfg = memRd;
        end

        // Remote command execution; every command gets one answer
        if (cmd.valid) begin
            n.rsp.valid = 1'b1;
            n.rsp.ok = 1'b1;
            case (cmd.op)
                OP_FB_MODE: begin
                    if (cmd.arg <= ARG_SEL_MAX) begin
                        n.cfg.fbMode = fb_mode_t'(cmd.arg[1:0]);
                    end else begin
                        n.rsp.ok = 1'b0;
                    end
                end
                OP_FB_DELAY: begin
                    // Steps of 0.1 s; out-of-range values are refused
                    if (inRange(cmd.arg, ARG_DLY_MIN, ARG_DLY_MAX)) begin
                        n.cfg.fbDelay = cmd.arg[DLY_W-1:0];
                    end else begin
                        n.rsp.ok = 1'b0;
                    end
                end
                OP_ALARM_MASK: begin
                    n.alarmDisableMask = cmd.arg[ALM_W-1:0] & ALM_USED;
                end
                OP_OT_LATCH: n.otLatchEn = cmd.arg[0];
                OP_ILK: n.ilkEn = cmd.arg[0];
                OP_SAVE: n.rsp.ok = slotOk;
                OP_RECALL: begin
                    n.rsp.ok = slotOk;
                    n.recallPend = slotOk;
                end
                OP_LEVEL: begin
                    if (inRange(cmd.arg, ARG_LVL_MIN, ARG_LVL_MAX)) begin
                        n.cfg.analogFullscaleLevel[cmd.sel] =
                            cmd.arg[3:0];
                    end else begin
                        n.rsp.ok = 1'b0;
                    end
                end
                OP_SOURCE: begin
                    if (cmd.arg <= ARG_SEL_MAX) begin
                        n.cfg.source[cmd.sel] = src_t'(cmd.arg[1:0]);
                    end else begin
                        n.rsp.ok = 1'b0;
                    end
                end
                OP_PROT_CLEAR: n.rsp.ok = s.holdArmed;
                OP_QUERY: begin
                    // Status shows only unmasked alarms
                    n.rsp.data[ALM_W:0] = visAll;
                    // Masked foldback hides the off bit too
                    n.rsp.data[ST_OFF] = s.outputOff
                        & ~s.alarmDisableMask[ALM_FB];
                end
                default: n.rsp.ok = 1'b0;
            endcase
        end
    end

    // State register; reset gives defaults and interlock off
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s <= '0;
            s.cfg <= CFG_RST;
            s.alarmDisableMask <= MASK_RST;
            s.ilkEn <= 1'b0;
            s.fbState <= FB_IDLE;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from the state register
    assign rsp = s.rsp;
    assign outputOff = s.outputOff;
    assign alarmOut = s.alarmOut;
    assign statusEvent = s.statusEvent;
    assign usrCfg = s.cfg;

    // Checks on the block's own behaviour
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // Last tick in the selected mode
    sequence trip_seq;
        (s.fbState == FB_COUNT) && inSel && fbTick
            && ((s.fbCnt + 9'h001) >= s.cfg.fbDelay);
    endsequence

    // Output held off
    sequence shut_seq;
        (s.fbState == FB_TRIP) && s.outputOff;
    endsequence

    a_fb_trip_shut: assert property (trip_seq |=> shut_seq)
        else $error("foldback expiry did not shut the output");
    a_count_in_mode: assert property (
        (s.fbState == FB_COUNT) |-> $past(inSel))
        else $error("foldback counted outside the selected mode");
    a_none_no_fb: assert property (
        (s.cfg.fbMode == FB_DISABLED) && (s.fbState != FB_TRIP)
            |=> (s.fbState == FB_IDLE))
        else $error("foldback ran while disabled");
    a_reset_defaults: assert property (
        $past(rst) |-> (s.cfg.fbMode == FB_DISABLED))
        else $error("foldback trigger not disabled after reset");
    a_reset_delay: assert property (
        $past(rst) |-> (s.cfg.fbDelay == DLY_RST))
        else $error("foldback delay not half a second after reset");
    a_reset_ilk: assert property ($past(rst) |-> !s.ilkEn)
        else $error("interlock enabled after reset");
    a_delay_reject: assert property (
        cmd.valid && (cmd.op == OP_FB_DELAY) && !s.recallPend
            && !inRange(cmd.arg, ARG_DLY_MIN, ARG_DLY_MAX)
            |=> s.rsp.valid && !s.rsp.ok && $stable(s.cfg.fbDelay))
        else $error("out of range delay accepted");
    a_clear_hold: assert property (
        (s.fbState == FB_TRIP) && !(clrCmd && s.holdArmed)
            |=> (s.fbState == FB_TRIP) [*1] ##0 s.outputOff)
        else $error("foldback cleared without hold and command");
    a_otp_masked: assert property (
        $past(s.alarmDisableMask[ALM_OTP]) |-> !s.prevVisible[ALM_OTP])
        else $error("masked over-temperature alarm visible");
    a_otp_latch: assert property (
        s.otLatchEn && s.otLatched && !clrCmd
            && !(cmd.valid && (cmd.op == OP_OT_LATCH)) |=> s.otLatched)
        else $error("latched over-temperature alarm dropped");
    a_ilk_unmasked: assert property (
        s.prevVisible[ST_ILK] == $past(s.ilkEn & pinSync[PIN_W-1]))
        else $error("interlock alarm affected by mask");
    a_ilk_cmd_only: assert property (
        !(cmd.valid && (cmd.op == OP_ILK)) |=> $stable(s.ilkEn))
        else $error("interlock enable changed without command");
    a_slot_reject: assert property (
        cmd.valid && ((cmd.op == OP_SAVE) || (cmd.op == OP_RECALL))
            && !slotOk |=> s.rsp.valid && !s.rsp.ok)
        else $error("bad settings slot accepted");
    a_level_range: assert property (
        cmd.valid && (cmd.op == OP_LEVEL) && !s.recallPend
            && !inRange(cmd.arg, ARG_LVL_MIN, ARG_LVL_MAX)
            |=> !s.rsp.ok && $stable(s.cfg.analogFullscaleLevel))
        else $error("out of range full-scale level accepted");
    a_event_rise: assert property (
        |(visAll & ~s.prevVisible) |=> s.statusEvent && s.alarmOut)
        else $error("new alarm raised no status event");
    a_unused_bits: assert property (
        (s.prevVisible[ALM_W-1:0] & ~ALM_USED) == '0)
        else $error("unused alarm bit became visible");
    a_status_hidden: assert property (
        cmd.valid && (cmd.op == OP_QUERY)
            |=> ((s.rsp.data[ALM_W-1:0] & s.alarmDisableMask) == '0))
        else $error("masked alarm shown in status");
endmodule
`default_nettype wire

// ==== host_cmd_model.sv ====
// Host model: issues one decoded command and collects its answer.
// Assumes the answer arrives within three cycles of the taking edge.
`timescale 1ns/1ps
`default_nettype none
module host_cmd_model (
    input wire logic clk_sys,
    output prot_alarm_pkg::cmd_t cmd,
    input wire prot_alarm_pkg::rsp_t rsp
);
    import prot_alarm_pkg::*;
    logic gotRsp; // Answer seen for the last command
    // Idle strobe from time zero
    initial begin
        cmd = '0;
    end
    // Calibration order (gain, offset, gain) is the operator's job
    // Only this remote path writes settings and interlock enable
    task automatic send(input cmd_op_t op, input logic [1:0] sel,
            input logic [15:0] arg, output rsp_t got);
        gotRsp = 1'b0;
        got = '0;
        @(posedge clk_sys);
        #1 cmd = '{1'b1, op, sel, arg};
        @(posedge clk_sys);
        #1 cmd = '0;
        // Bounded wait, a missing answer shows as got.valid low
        for (int i = 0; i < 3 && !gotRsp; i++) begin
            if (rsp.valid === 1'b1) begin
                gotRsp = 1'b1;
                got = rsp;
            end else begin
                @(posedge clk_sys);
                #1;
            end
        end
    endtask
endmodule
`default_nettype wire

// ==== test_protection_alarm_control.sv ====
// Self-checking bench for the protection and alarm block.
// Assumes host_cmd_model drives the command port.
`timescale 1ns/1ps
`default_nettype none
module test_protection_alarm_control;
    import prot_alarm_pkg::*;
    localparam int TICKS = 4; // Short delay tick keeps runs brief
    logic clk_sys, rst, regCurrentPin, regVoltagePin, enterBtnPin;
    logic interlockPin, outputOff, alarmOut, statusEvent;
    logic [ALM_W-1:0] alarmPin;
    cmd_t cmd;
    rsp_t rsp, got;
    usr_cfg_t usrCfg;
    int fail_count = 0;
    int n_compared = 0;
    int n;
    int evCount = 0; // Event pulses so far
    int ev0; // Count before a check

    protection_alarm_control #(.TICK_CYCLES(TICKS)) i_dut (
        .clk_sys(clk_sys), .rst(rst), .cmd(cmd),
        .regCurrentPin(regCurrentPin), .regVoltagePin(regVoltagePin),
        .enterBtnPin(enterBtnPin), .alarmPin(alarmPin),
        .interlockPin(interlockPin), .rsp(rsp), .outputOff(outputOff),
        .alarmOut(alarmOut), .statusEvent(statusEvent), .usrCfg(usrCfg));
    host_cmd_model i_host (.clk_sys(clk_sys), .cmd(cmd), .rsp(rsp));

    // Clock, 10 ns period
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Count the one-cycle event pulses
    always @(posedge clk_sys) begin
        if (statusEvent === 1'b1) evCount <= evCount + 1;
    end

    task automatic chk(input string what, input logic [35:0] exp,
            input logic [35:0] seen);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cycles(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    // Send and judge the accept flag
    task automatic cmdOk(input cmd_op_t op, input logic [1:0] sel,
            input logic [15:0] arg, input logic expOk);
        i_host.send(op, sel, arg, got);
        chk("answer", {1'b1, expOk}, {got.valid, got.ok});
    endtask
    // Bounded wait for shutdown, n counts cycles taken
    task automatic waitOff();
        for (n = 0; n < 5 * TICKS + 20 && outputOff !== 1'b1; n++) cycles(1);
    endtask
    task automatic query(input logic [8:0] exp);
        i_host.send(OP_QUERY, 2'h0, 16'h0000, got);
        chk("status", exp, got.data[8:0]);
    endtask

    task automatic t_reset();
        chk("config", CFG_RST, usrCfg);
        chk("off", 0, {outputOff, alarmOut});
        $display("test reset done");
    endtask
    task automatic t_delay();
        logic [15:0] args[4] = '{16'h0004, 16'h0005, 16'h01f4, 16'h01f5};
        logic oks[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 4; i++) begin
            cmdOk(OP_FB_DELAY, 2'h0, args[i], oks[i]);
        end
        cycles(1);
        chk("delay", 9'h1f4, usrCfg.fbDelay);
        cmdOk(OP_FB_DELAY, 2'h0, 16'h0005, 1'b1);
        $display("test delay done");
    endtask
    task automatic t_fold();
        cmdOk(OP_FB_MODE, 2'h0, 16'h0001, 1'b1);
        regVoltagePin = 1'b1;
        cycles(60);
        chk("cv ignored", 0, outputOff);
        regVoltagePin = 1'b0;
        ev0 = evCount;
        regCurrentPin = 1'b1;
        waitOff();
        chk("cc trip", 1, outputOff);
        chk("not early", 1, n >= 5 * TICKS);
        cycles(3);
        chk("trip event", 1, evCount > ev0);
        regCurrentPin = 1'b0;
        cmdOk(OP_PROT_CLEAR, 2'h0, 16'h0000, 1'b0);
        cycles(2);
        chk("stays off", 1, outputOff);
        enterBtnPin = 1'b1;
        cycles(HOLD_TICKS * TICKS + 10);
        cmdOk(OP_PROT_CLEAR, 2'h0, 16'h0000, 1'b1);
        cycles(2);
        chk("cleared", 0, outputOff);
        cmdOk(OP_FB_MODE, 2'h0, 16'h0000, 1'b1);
        regCurrentPin = 1'b1;
        cycles(60);
        chk("none idle", 0, outputOff);
        regCurrentPin = 1'b0;
        // Button still held, so the second clear needs no new hold
        cmdOk(OP_FB_MODE, 2'h0, 16'h0002, 1'b1);
        regVoltagePin = 1'b1;
        waitOff();
        chk("cv trip", 1, outputOff);
        regVoltagePin = 1'b0;
        cmdOk(OP_PROT_CLEAR, 2'h0, 16'h0000, 1'b1);
        enterBtnPin = 1'b0;
        cmdOk(OP_FB_MODE, 2'h0, 16'h0000, 1'b1);
        $display("test foldback done");
    endtask
    task automatic t_alarm();
        int bits[5] = '{1, 2, 3, 4, 8};
        cmdOk(OP_ALARM_MASK, 2'h0, 16'h0008, 1'b1);
        alarmPin[3] = 1'b1;
        cycles(8);
        chk("masked", 0, alarmOut);
        query(9'h000);
        ev0 = evCount;
        cmdOk(OP_ALARM_MASK, 2'h0, 16'h0000, 1'b1);
        cycles(8);
        chk("unmasked", 2'b11, {alarmOut, evCount > ev0});
        alarmPin = 9'h1ff;
        cycles(8);
        query(9'h11e);
        foreach (bits[i]) begin
            cmdOk(OP_ALARM_MASK, 2'h0, 16'h01ff ^ (16'h1 << bits[i]), 1'b1);
            query(9'h001 << bits[i]);
        end
        alarmPin = 9'h000;
        cmdOk(OP_ALARM_MASK, 2'h0, 16'h0000, 1'b1);
        cmdOk(OP_OT_LATCH, 2'h0, 16'h0001, 1'b1);
        alarmPin[3] = 1'b1;
        cycles(8);
        alarmPin[3] = 1'b0;
        cycles(8);
        chk("latched", 1, alarmOut);
        cmdOk(OP_PROT_CLEAR, 2'h0, 16'h0000, 1'b0);
        cycles(2);
        chk("unlatched", 0, alarmOut);
        cmdOk(OP_OT_LATCH, 2'h0, 16'h0000, 1'b1);
        alarmPin[3] = 1'b1;
        cycles(8);
        chk("follows high", 1, alarmOut);
        alarmPin[3] = 1'b0;
        cycles(8);
        chk("follows", 0, alarmOut);
        $display("test alarm done");
    endtask
    task automatic t_ilk();
        interlockPin = 1'b1;
        cycles(8);
        chk("ilk off", 0, alarmOut);
        cmdOk(OP_ILK, 2'h0, 16'h0001, 1'b1);
        cmdOk(OP_ALARM_MASK, 2'h0, 16'h01ff, 1'b1);
        cycles(8);
        chk("ilk on", 1, alarmOut);
        cmdOk(OP_ILK, 2'h0, 16'h0000, 1'b1);
        cycles(8);
        chk("ilk cut", 0, alarmOut);
        interlockPin = 1'b0;
        cmdOk(OP_ALARM_MASK, 2'h0, 16'h0000, 1'b1);
        $display("test interlock done");
    endtask
    task automatic t_slot();
        for (int s = 1; s <= 3; s++) begin
            cmdOk(OP_FB_DELAY, 2'h0, 16'(10 + s), 1'b1);
            cmdOk(OP_SAVE, 2'h0, 16'(s), 1'b1);
        end
        cmdOk(OP_SAVE, 2'h0, 16'h0000, 1'b0);
        cmdOk(OP_RECALL, 2'h0, 16'h0004, 1'b0);
        for (int s = 3; s >= 1; s--) begin
            cmdOk(OP_RECALL, 2'h0, 16'(s), 1'b1);
            cycles(2);
            chk("recall", 10 + s, usrCfg.fbDelay);
        end
        $display("test slots done");
    endtask
    task automatic t_level();
        for (int p = 0; p < 4; p++) begin
            cmdOk(OP_LEVEL, 2'(p), 16'h0001, 1'b0);
            cmdOk(OP_LEVEL, 2'(p), 16'h000b, 1'b0);
            cmdOk(OP_LEVEL, 2'(p), 16'(2 + p), 1'b1);
            cmdOk(OP_SOURCE, 2'(p), 16'h0003, 1'b0);
            for (int s = 0; s < 3; s++) begin
                cmdOk(OP_SOURCE, 2'(p), 16'(s), 1'b1);
            end
            cycles(1);
            chk("level", 2 + p, usrCfg.analogFullscaleLevel[p]);
            chk("source", RESISTIVE_SOURCE, usrCfg.source[p]);
        end
        $display("test level done");
    endtask

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Run takes several hundred cycles; this bound is far beyond that
    initial begin
        #400000;
        fail_count++;
        test_done();
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        {regCurrentPin, regVoltagePin, enterBtnPin, interlockPin} = '0;
        alarmPin = '0;
        cycles(8);
        rst = 1'b0;
        cycles(1);
        t_reset();
        t_delay();
        t_fold();
        t_alarm();
        t_ilk();
        t_slot();
        t_level();
        test_done();
    end
endmodule
`default_nettype wire
